// ===== logic/ybs_cycle_plan.sv
/*
 * Per-cycle bus plan: for a group and a cycle number, which address,
 * which read/write level and which write data the cycle carries.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module ybs_cycle_plan (
    // Cycle to plan.
    input  wire ybs_pkg::ybs_grp_type  grp_i,
    input  wire logic [3:0]            cyc_i,
    // Plan for that cycle.
    output ybs_pkg::ybs_asel_type      asel_o,
    output ybs_pkg::ybs_wsel_type      wsel_o,
    output logic                       rw_o
);
    import ybs_pkg::*;

    // Cycles one to four are common; the group shapes the rest.
    always_comb begin
        asel_o = A_ONES;
        wsel_o = W_NONE;
        case (cyc_i)
            4'h1: asel_o = A_OPC1;
            4'h2: asel_o = A_OPC2;
            4'h3: asel_o = A_OPC3;
            CYC_OPND: begin
                asel_o = A_EA;
                if (grp_i == GRP_ACC_STORE) begin
                    wsel_o = W_ACC;
                end else if (grp_i == GRP_STORE16) begin
                    wsel_o = W_REG_HI;
                end
            end
            CYC_SIX: begin
                case (grp_i)
                    GRP_LOAD16, GRP_ARITH16: asel_o = A_EA1;
                    GRP_STORE16: begin
                        asel_o = A_EA1;
                        wsel_o = W_REG_LO;
                    end
                    GRP_CALL: begin
                        asel_o = A_SP;
                        wsel_o = W_RET_LO;
                    end
                    GRP_BIT_MOD, GRP_BIT_BRANCH: asel_o = A_OPC4;
                    default: asel_o = A_ONES;
                endcase
            end
            CYC_SEVEN: begin
                case (grp_i)
                    GRP_RMW: begin
                        asel_o = A_EA;
                        wsel_o = W_RESULT;
                    end
                    GRP_CALL: begin
                        asel_o = A_SPM1;
                        wsel_o = W_RET_HI;
                    end
                    GRP_BIT_BRANCH: asel_o = A_OPC4;
                    default: asel_o = A_ONES;
                endcase
            end
            CYC_EIGHT: begin
                if (grp_i == GRP_BIT_MOD) begin
                    asel_o = A_EA;
                    wsel_o = W_RESULT;
                end
            end
            default: asel_o = A_ONES;
        endcase
        // Read level everywhere except a write cycle.
        rw_o = (wsel_o == W_NONE);
    end

endmodule

// ===== logic/ybs_pkg.sv
/*
 * Shared definitions for the indexed bus cycle sequencer: opcode values,
 * instruction groups, address and write-data selectors, cycle counts and
 * instruction lengths.
 * Assumes a 16-bit address bus and an 8-bit data bus.
 */
package ybs_pkg;

    // Opcode bytes: the prefix, which the sequencer never checks, and three that it recognises by itself.
    localparam logic [7:0]  PREFIX_OP     = 8'h18;
    localparam logic [7:0]  JUMP_OP       = 8'h6e;
    localparam logic [7:0]  MEMORY_TEST_OP = 8'h6d;
    localparam logic [7:0]  SUBROUTINE_CALL_OP = 8'had;

    // Address driven in every cycle whose data is of no interest.
    localparam logic [15:0] ALL_ONES_ADDR = 16'hffff;

    // Instruction groups; the core names all but the three fixed opcodes.
    typedef enum logic [3:0] {
        GRP_ACC_READ   = 4'h0,
        GRP_ACC_STORE  = 4'h1,
        GRP_RMW        = 4'h2,
        GRP_LOAD16     = 4'h3,
        GRP_STORE16    = 4'h4,
        GRP_ARITH16    = 4'h5,
        GRP_BIT_MOD    = 4'h6,
        GRP_BIT_BRANCH = 4'h7,
        GRP_JUMP       = 4'h8,
        GRP_MEMTEST    = 4'h9,
        GRP_CALL       = 4'ha
    } ybs_grp_type;

    // Source of the address for one bus cycle.
    typedef enum logic [3:0] {
        A_OPC1 = 4'h0, A_OPC2 = 4'h1, A_OPC3 = 4'h2, A_OPC4 = 4'h3,
        A_ONES = 4'h4, A_EA = 4'h5, A_EA1 = 4'h6, A_SP = 4'h7,
        A_SPM1 = 4'h8
    } ybs_asel_type;

    // Source of the data byte in a write cycle.
    typedef enum logic [2:0] {
        W_NONE = 3'h0, W_ACC = 3'h1, W_REG_HI = 3'h2, W_REG_LO = 3'h3,
        W_RESULT = 3'h4, W_RET_LO = 3'h5, W_RET_HI = 3'h6
    } ybs_wsel_type;

    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } ybs_state_type;

    // Cycle numbers that fix where captures happen.
    localparam logic [3:0] CYC_OPCODE2 = 4'h2;
    localparam logic [3:0] CYC_OFFSET  = 4'h3;
    localparam logic [3:0] CYC_DUMMY   = 4'h4;
    localparam logic [3:0] CYC_OPND    = 4'h5;
    localparam logic [3:0] CYC_SIX     = 4'h6;
    localparam logic [3:0] CYC_SEVEN   = 4'h7;
    localparam logic [3:0] CYC_EIGHT   = 4'h8;

    // Cycle counts per group.
    localparam logic [3:0] LEN_JUMP   = 4'h4;
    localparam logic [3:0] LEN_ACC    = 4'h5;
    localparam logic [3:0] LEN_WORD   = 4'h6;
    localparam logic [3:0] LEN_LONG   = 4'h7;
    localparam logic [3:0] LEN_BITOP  = 4'h8;

    // Instruction lengths in bytes, for the fall-through address.
    localparam logic [15:0] BYTES_PLAIN  = 16'h0003;
    localparam logic [15:0] BYTES_BITMOD = 16'h0004;
    localparam logic [15:0] BYTES_BRANCH = 16'h0005;

    // Number of bus cycles an instruction of a group takes.
    function automatic logic [3:0] grp_len(input ybs_grp_type g);
        case (g)
            GRP_JUMP:                           grp_len = LEN_JUMP;
            GRP_ACC_READ, GRP_ACC_STORE:        grp_len = LEN_ACC;
            GRP_LOAD16, GRP_STORE16:            grp_len = LEN_WORD;
            GRP_BIT_MOD, GRP_BIT_BRANCH:        grp_len = LEN_BITOP;
            default:                            grp_len = LEN_LONG;
        endcase
    endfunction

endpackage

// ===== logic/ybs_sequencer.sv
/*
 * Bus cycle sequencer for the indexed mode that uses the second index
 * register. It walks the bus one cycle per clock and registers address,
 * read/write level and write data for each cycle.
 * Assumes the core names the group of the second opcode byte on CLASS_I
 * in cycle 2 and holds ACC_I, REG16_I, RESULT_I, SECOND_INDEX_I and SP_I steady.
 */
`timescale 1ns/1ps
module ybs_sequencer (
    // Clock and reset.
    input  wire logic                  SYS_CLK_I,
    input  wire logic                  ARST_N_I,
    // Instruction start and core state.
    input  wire logic                  START_I,
    input  wire logic [15:0]           OPC_ADDR_I,
    input  wire ybs_pkg::ybs_grp_type  CLASS_I,
    input  wire logic [15:0]           SECOND_INDEX_I,
    input  wire logic [15:0]           SP_I,
    input  wire logic [7:0]            ACC_I,
    input  wire logic [15:0]           REG16_I,
    input  wire logic [7:0]            RESULT_I,
    // Memory bus.
    input  wire logic [7:0]            DATA_I,
    output logic [15:0]                ADDR_O,
    output logic                       RW_O,
    output logic [7:0]                 DATA_O,
    // Progress and results to the core.
    output logic                       BUSY_O,
    output logic                       DONE_O,
    output logic [3:0]                 CYCLE_O,
    output logic [15:0]                NEXT_PC_O,
    output logic [15:0]                OPERAND_O,
    output logic [7:0]                 MASK_O,
    output logic [7:0]                 BRANCH_OFS_O
);
    import ybs_pkg::*;

    typedef struct packed {
        ybs_state_type st;
        logic [3:0]    cyc;
        ybs_grp_type   grp;
        logic [15:0]   opc;
        logic [15:0]   ea;
        logic [15:0]   addr;
        logic          rw;
        logic [7:0]    dout;
        logic          done;
        logic [15:0]   next_pc;
        logic [15:0]   operand;
        logic [7:0]    mask;
        logic [7:0]    bofs;
    } ybs_regs_type;

    ybs_regs_type s_q;
    ybs_regs_type s_d;
    logic         last;
    logic         go;
    logic [3:0]   nc;
    ybs_asel_type asel;
    ybs_wsel_type wsel;
    logic         plan_rw;
    logic [15:0]  ret_addr;

    // A new instruction may start in the last cycle of the previous one,
    // so back-to-back instructions lose no bus cycle.
    always_comb begin
        last = (s_q.st == ST_RUN) && (s_q.cyc == grp_len(s_q.grp));
        go   = START_I && ((s_q.st == ST_IDLE) || last);
        if (go) begin
            nc = 4'h1;
        end else if ((s_q.st == ST_IDLE) || last) begin
            nc = 4'h0;
        end else begin
            nc = s_q.cyc + 4'h1;
        end
    end

    ybs_cycle_plan u_plan (
        .grp_i  (s_q.grp),
        .cyc_i  (nc),
        .asel_o (asel),
        .wsel_o (wsel),
        .rw_o   (plan_rw)
    );

    assign ret_addr = s_q.opc + BYTES_PLAIN;

    // Next-state logic: captures of the current cycle, plan of the next.
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (s_q.st == ST_RUN) begin
            case (s_q.cyc)
                CYC_OPCODE2: begin
                    case (DATA_I)
                        JUMP_OP:            s_d.grp = GRP_JUMP;
                        MEMORY_TEST_OP:     s_d.grp = GRP_MEMTEST;
                        SUBROUTINE_CALL_OP: s_d.grp = GRP_CALL;
                        default:            s_d.grp = CLASS_I;
                    endcase
                end
                CYC_OFFSET: begin
                    s_d.ea = SECOND_INDEX_I + {8'h00, DATA_I};
                end
                CYC_OPND: begin
                    // A fresh operand starts here, so the byte read in a
                    // final cycle still stands when a new start follows.
                    if (s_q.rw) begin
                        s_d.operand = {8'h00, DATA_I};
                    end
                end
                CYC_SIX: begin
                    if (s_q.grp == GRP_BIT_MOD
                        || s_q.grp == GRP_BIT_BRANCH) begin
                        s_d.mask = DATA_I;
                    end else if (s_q.grp == GRP_LOAD16
                        || s_q.grp == GRP_ARITH16) begin
                        s_d.operand = {s_q.operand[7:0], DATA_I};
                    end
                end
                CYC_SEVEN: begin
                    if (s_q.grp == GRP_BIT_BRANCH) begin
                        s_d.bofs = DATA_I;
                    end
                end
                default: s_d.bofs = s_q.bofs;
            endcase
        end
        if (go) begin
            s_d.st      = ST_RUN;
            s_d.opc     = OPC_ADDR_I;
        end else if (nc == 4'h0) begin
            s_d.st = ST_IDLE;
        end
        s_d.cyc = nc;
        // Address for the cycle about to start.
        case (asel)
            A_OPC1:  s_d.addr = go ? OPC_ADDR_I : s_q.opc;
            A_OPC2:  s_d.addr = s_q.opc + 16'h0001;
            A_OPC3:  s_d.addr = s_q.opc + 16'h0002;
            A_OPC4:  s_d.addr = s_q.opc + 16'h0003;
            A_EA:    s_d.addr = s_q.ea;
            A_EA1:   s_d.addr = s_q.ea + 16'h0001;
            A_SP:    s_d.addr = SP_I;
            A_SPM1:  s_d.addr = SP_I - 16'h0001;
            default: s_d.addr = ALL_ONES_ADDR;
        endcase
        if (asel == A_OPC4 && nc == CYC_SEVEN) begin
            s_d.addr = s_q.opc + 16'h0004;
        end
        // Idle cycles park the bus on a harmless read.
        s_d.rw = (nc == 4'h0) ? 1'b1 : plan_rw;
        case (wsel)
            W_ACC:    s_d.dout = ACC_I;
            W_REG_HI: s_d.dout = REG16_I[15:8];
            W_REG_LO: s_d.dout = REG16_I[7:0];
            W_RESULT: s_d.dout = RESULT_I;
            W_RET_LO: s_d.dout = ret_addr[7:0];
            W_RET_HI: s_d.dout = ret_addr[15:8];
            default:  s_d.dout = 8'h00;
        endcase
        // Flag the final cycle and where fetching continues.
        if (nc != 4'h0 && !go && nc == grp_len(s_q.grp)) begin
            s_d.done = 1'b1;
            case (s_q.grp)
                GRP_JUMP, GRP_CALL: s_d.next_pc = s_d.ea;
                GRP_BIT_MOD:    s_d.next_pc = s_q.opc + BYTES_BITMOD;
                GRP_BIT_BRANCH: s_d.next_pc = s_q.opc + BYTES_BRANCH;
                default:        s_d.next_pc = ret_addr;
            endcase
        end
    end

    // All sequencer state lives in one register.
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s_q         <= '0;
            s_q.st      <= ST_IDLE;
            s_q.grp     <= GRP_ACC_READ;
            s_q.addr    <= ALL_ONES_ADDR;
            s_q.rw      <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign ADDR_O       = s_q.addr;
    assign RW_O         = s_q.rw;
    assign DATA_O       = s_q.dout;
    assign BUSY_O       = s_q.st[1];                // One-hot run bit.
    assign DONE_O       = s_q.done;
    assign CYCLE_O      = s_q.cyc;
    assign NEXT_PC_O    = s_q.next_pc;
    assign OPERAND_O    = s_q.operand;
    assign MASK_O       = s_q.mask;
    assign BRANCH_OFS_O = s_q.bofs;

    // Checks on the bus walk; each ties a cycle to its address and level, except a_jump and a_ea, which check NEXT_PC_O and the effective address.
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    property p_fetch;
        s_q.cyc == 4'h2 |-> ADDR_O == s_q.opc + 16'h0001 && RW_O
            ##1 ADDR_O == s_q.opc + 16'h0002 ##1 ADDR_O == ALL_ONES_ADDR;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch cycles off their addresses");

    property p_jump;
        s_q.cyc == 4'h4 && s_q.grp == GRP_JUMP |-> DONE_O
            && NEXT_PC_O == s_q.ea;
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump did not end in cycle 4");

    property p_acc_store;
        s_q.cyc == 4'h5 && s_q.grp == GRP_ACC_STORE |-> !RW_O
            && ADDR_O == s_q.ea && DATA_O == $past(ACC_I) && DONE_O;
    endproperty
    a_acc_store: assert property (p_acc_store)
        else $error("accumulator store cycle wrong");

    property p_rmw;
        s_q.cyc == 4'h5 && s_q.grp == GRP_RMW |-> RW_O ##1
            ADDR_O == ALL_ONES_ADDR ##1 (!RW_O && ADDR_O == s_q.ea && DONE_O);
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("read-modify-write walk wrong");

    property p_memtest;
        s_q.cyc == 4'h5 && s_q.grp == GRP_MEMTEST |-> RW_O [*3]
            ##0 (DONE_O && ADDR_O == ALL_ONES_ADDR);
    endproperty
    a_memtest: assert property (p_memtest)
        else $error("memory test wrote or ran long");

    property p_load16;
        s_q.cyc == 4'h6 && s_q.grp == GRP_LOAD16 |-> RW_O && DONE_O
            && ADDR_O == s_q.ea + 16'h0001;
    endproperty
    a_load16: assert property (p_load16)
        else $error("16-bit load low byte wrong");

    property p_store16;
        s_q.cyc == 4'h5 && s_q.grp == GRP_STORE16 |-> !RW_O
            ##1 (!RW_O && ADDR_O == $past(ADDR_O) + 16'h0001);
    endproperty
    a_store16: assert property (p_store16)
        else $error("16-bit store walk wrong");

    property p_arith16;
        s_q.cyc == 4'h7 && s_q.grp == GRP_ARITH16 |-> RW_O && DONE_O
            && ADDR_O == ALL_ONES_ADDR;
    endproperty
    a_arith16: assert property (p_arith16)
        else $error("16-bit arithmetic end wrong");

    property p_call;
        s_q.cyc == 4'h5 && s_q.grp == GRP_CALL |-> RW_O && ADDR_O == s_q.ea;
    endproperty
    a_call: assert property (p_call)
        else $error("call target read wrong");

    property p_call_push;
        s_q.cyc == 4'h6 && s_q.grp == GRP_CALL |-> !RW_O
            ##1 (!RW_O && ADDR_O == $past(ADDR_O) - 16'h0001 && DONE_O);
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("return address push wrong");

    property p_bit_mod;
        s_q.cyc == 4'h6 && s_q.grp == GRP_BIT_MOD |->
            ADDR_O == s_q.opc + 16'h0003 ##2 (!RW_O && ADDR_O == s_q.ea);
    endproperty
    a_bit_mod: assert property (p_bit_mod)
        else $error("bit modify walk wrong");

    property p_bit_branch;
        s_q.cyc == 4'h7 && s_q.grp == GRP_BIT_BRANCH |->
            ADDR_O == s_q.opc + 16'h0004
            ##1 (RW_O && DONE_O && ADDR_O == ALL_ONES_ADDR);
    endproperty
    a_bit_branch: assert property (p_bit_branch)
        else $error("bit branch walk wrong");

    property p_ea;
        s_q.cyc == 4'h4 |-> s_q.ea == 16'($past(SECOND_INDEX_I)
            + {8'h00, $past(DATA_I)}) && RW_O;
    endproperty
    a_ea: assert property (p_ea)
        else $error("effective address wrong");

    c_jump: cover property (s_q.grp == GRP_JUMP && DONE_O);
    c_call: cover property (s_q.grp == GRP_CALL && DONE_O);
    c_branch: cover property (s_q.grp == GRP_BIT_BRANCH && DONE_O);
    c_b2b: cover property (DONE_O ##1 s_q.cyc == 4'h1);

endmodule

// ===== verif/indexed_y_bus_cycle_sequencer_test.sv
/*
 * Self-checking bench for the indexed bus cycle sequencer: one task per
 * instruction group, traced cycle by cycle and compared with the plan.
 * Assumes the memory model answers reads; inputs change at falling edges.
 */
`timescale 1ns/1ps
module indexed_y_bus_cycle_sequencer_test;
    import ybs_pkg::*;
    logic        clk, arst_n, start, rw, busy, done;
    logic [15:0] opc, iy, sp, reg16, addr, npc, opnd;
    logic [7:0]  acc, res, din, dout, mask, bofs;
    logic [3:0]  cyc;
    ybs_grp_type cls;
    logic [15:0] t_addr [1:8];
    logic        t_rw [1:8];
    logic [7:0]  t_dat [1:8];
    int          n_fail, n_checks;

    ybs_sequencer ybs_sequencer_i (.SYS_CLK_I(clk), .ARST_N_I(arst_n),
        .START_I(start), .OPC_ADDR_I(opc), .CLASS_I(cls),
        .SECOND_INDEX_I(iy), .SP_I(sp), .ACC_I(acc), .REG16_I(reg16),
        .RESULT_I(res), .DATA_I(din), .ADDR_O(addr), .RW_O(rw),
        .DATA_O(dout), .BUSY_O(busy), .DONE_O(done), .CYCLE_O(cyc),
        .NEXT_PC_O(npc), .OPERAND_O(opnd), .MASK_O(mask),
        .BRANCH_OFS_O(bofs));
    ybs_mem_model ybs_mem_model_i (.clk_i(clk), .addr_i(addr),
        .rw_i(rw), .wdata_i(dout), .rdata_o(din));

    // Free-running clock at 50 MHz.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Starts one instruction and records every bus cycle up to DONE_O.
    // It returns in the last cycle, so the next call starts back to back.
    task automatic run(input logic [7:0] op2, input logic [7:0] ofs,
                       input ybs_grp_type g, input logic [3:0] len);
        int i;
        ybs_mem_model_i.mem[opc] = PREFIX_OP;
        ybs_mem_model_i.mem[opc + 16'h0001] = op2;
        ybs_mem_model_i.mem[opc + 16'h0002] = ofs;
        cls = g;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (i = 1; i <= 8; i++) begin
            t_addr[i] = addr;
            t_rw[i] = rw;
            t_dat[i] = dout;
            check({12'h000, cyc}, i[15:0]);
            check({15'h0000, busy}, 16'h0001);
            if (done === 1'b1) break;
            @(negedge clk);
        end
        if (i > 8) begin
            n_fail++;
            stop_test();
        end
        check(i[15:0], {12'h000, len});
        check(t_addr[1], opc);
        check(t_addr[2], opc + 16'h0001);
        check(t_addr[3], opc + 16'h0002);
        check(t_addr[4], ALL_ONES_ADDR);
        for (int k = 1; k <= 4; k++) check({15'h0, t_rw[k]}, 16'h1);
    endtask

    // Compares one recorded cycle; write data only where RW_O is low.
    task automatic cyc_is(input int i, input logic [15:0] a,
                          input logic w, input logic [7:0] d);
        check(t_addr[i], a);
        check({15'h0000, t_rw[i]}, {15'h0000, w});
        if (!w) check({8'h00, t_dat[i]}, {8'h00, d});
    endtask

    // The offset is unsigned and the sum wraps past the top of memory.
    task automatic t_jump();
        opc = 16'h0100;
        iy = 16'hffc0;
        run(JUMP_OP, 8'hf0, GRP_ACC_READ, 4'h4);
        check(npc, 16'h00b0);
    endtask

    task automatic t_acc_read();
        opc = 16'h0200;
        iy = 16'h1000;
        ybs_mem_model_i.mem[16'h1010] = 8'ha5;
        run(8'ha6, 8'h10, GRP_ACC_READ, 4'h5);
        cyc_is(5, 16'h1010, 1'b1, 8'h00);
        // The operand is taken at the edge that ends the last cycle.
        @(negedge clk);
        check(opnd, 16'h00a5);
    endtask

    task automatic t_acc_store();
        opc = 16'h0300;
        acc = 8'h3c;
        run(8'ha7, 8'h20, GRP_ACC_STORE, 4'h5);
        cyc_is(5, 16'h1020, 1'b0, 8'h3c);
    endtask

    task automatic t_rmw();
        opc = 16'h0400;
        res = 8'hc3;
        run(8'h64, 8'h30, GRP_RMW, 4'h7);
        cyc_is(5, 16'h1030, 1'b1, 8'h00);
        cyc_is(6, ALL_ONES_ADDR, 1'b1, 8'h00);
        cyc_is(7, 16'h1030, 1'b0, 8'hc3);
    endtask

    // The group code is given as a store to show it is ignored here.
    task automatic t_memtest();
        opc = 16'h0500;
        run(MEMORY_TEST_OP, 8'h40, GRP_ACC_STORE, 4'h7);
        cyc_is(5, 16'h1040, 1'b1, 8'h00);
        cyc_is(6, ALL_ONES_ADDR, 1'b1, 8'h00);
        cyc_is(7, ALL_ONES_ADDR, 1'b1, 8'h00);
    endtask

    // Offset ff makes the low byte address carry into the high byte.
    task automatic t_load16();
        opc = 16'h0600;
        iy = 16'h10f1;
        ybs_mem_model_i.mem[16'h11f0] = 8'h12;
        ybs_mem_model_i.mem[16'h11f1] = 8'h34;
        run(8'hec, 8'hff, GRP_LOAD16, 4'h6);
        cyc_is(5, 16'h11f0, 1'b1, 8'h00);
        cyc_is(6, 16'h11f1, 1'b1, 8'h00);
        @(negedge clk);
        check(opnd, 16'h1234);
        iy = 16'h1000;
    endtask

    task automatic t_store16();
        opc = 16'h0700;
        reg16 = 16'hbeef;
        run(8'hed, 8'h60, GRP_STORE16, 4'h6);
        cyc_is(5, 16'h1060, 1'b0, 8'hbe);
        cyc_is(6, 16'h1061, 1'b0, 8'hef);
    endtask

    task automatic t_arith16();
        opc = 16'h0800;
        run(8'he3, 8'h70, GRP_ARITH16, 4'h7);
        cyc_is(5, 16'h1070, 1'b1, 8'h00);
        cyc_is(6, 16'h1071, 1'b1, 8'h00);
        cyc_is(7, ALL_ONES_ADDR, 1'b1, 8'h00);
    endtask

    // Return address is the opcode address plus three.
    task automatic t_call();
        opc = 16'h0900;
        sp = 16'h01ff;
        run(SUBROUTINE_CALL_OP, 8'h80, GRP_ACC_READ, 4'h7);
        cyc_is(5, 16'h1080, 1'b1, 8'h00);
        cyc_is(6, 16'h01ff, 1'b0, 8'h03);
        cyc_is(7, 16'h01fe, 1'b0, 8'h09);
        check(npc, 16'h1080);
    endtask

    task automatic t_bitmod();
        opc = 16'h0a00;
        res = 8'h77;
        ybs_mem_model_i.mem[16'h0a03] = 8'h0f;
        run(8'h1c, 8'h90, GRP_BIT_MOD, 4'h8);
        cyc_is(5, 16'h1090, 1'b1, 8'h00);
        cyc_is(6, 16'h0a03, 1'b1, 8'h00);
        cyc_is(7, ALL_ONES_ADDR, 1'b1, 8'h00);
        cyc_is(8, 16'h1090, 1'b0, 8'h77);
        check({8'h00, mask}, 16'h000f);
        check(npc, 16'h0a04);
    endtask

    task automatic t_bitbranch();
        opc = 16'h0b00;
        ybs_mem_model_i.mem[16'h0b03] = 8'hf0;
        ybs_mem_model_i.mem[16'h0b04] = 8'h22;
        run(8'h1e, 8'ha0, GRP_BIT_BRANCH, 4'h8);
        cyc_is(5, 16'h10a0, 1'b1, 8'h00);
        cyc_is(6, 16'h0b03, 1'b1, 8'h00);
        cyc_is(7, 16'h0b04, 1'b1, 8'h00);
        cyc_is(8, ALL_ONES_ADDR, 1'b1, 8'h00);
        check({bofs, mask}, 16'h22f0);
        check(npc, 16'h0b05);
    endtask

    // Reset, then every group back to back except after t_acc_read and t_load16, then an idle check.
    initial begin
        n_fail = 0;
        n_checks = 0;
        arst_n = 1'b0;
        start = 1'b0;
        opc = 16'h0000;
        iy = 16'h1000;
        sp = 16'h0100;
        reg16 = 16'h0000;
        acc = 8'h00;
        res = 8'h00;
        cls = GRP_ACC_READ;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        check(addr, ALL_ONES_ADDR);
        check({14'h0, rw, busy}, 16'h2);
        t_jump();
        t_acc_read();
        t_acc_store();
        t_rmw();
        t_memtest();
        t_load16();
        t_store16();
        t_arith16();
        t_call();
        t_bitmod();
        t_bitbranch();
        @(negedge clk);
        check({12'h0, cyc}, 16'h0000);
        check({15'h0, rw}, 16'h0001);
        stop_test();
    end
endmodule

// ===== verif/ybs_mem_model.sv
/*
 * Behavioural memory on the far side of the sequencer's bus.
 * Assumes registered address and read/write level from the sequencer;
 * reads are answered within the bus cycle, writes land at its end.
 */
`timescale 1ns/1ps
module ybs_mem_model (
    // Clock.
    input  wire logic        clk_i,
    // Bus from the sequencer.
    input  wire logic [15:0] addr_i,
    input  wire logic        rw_i,
    input  wire logic [7:0]  wdata_i,
    // Read data back.
    output logic [7:0]       rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;

    // Fill with a known pattern so dummy reads never return unknowns.
    initial begin
        last_q = 8'h00;
        for (int k = 0; k < 65536; k++) begin
            mem[k] = k[7:0] ^ 8'h5a;
        end
    end

    // During a write the data line is not driven by memory, so it shows
    // the inverse of the last value instead of a stale copy.
    always_comb begin
        rdata_o = rw_i ? mem[addr_i] : ~last_q;
    end

    // Writes land at the edge that ends the bus cycle. A plain always is
    // used because the bench preloads the same array between cycles.
    always @(posedge clk_i) begin
        if (!rw_i) begin
            mem[addr_i] <= wdata_i;
        end
        last_q <= rdata_o;
    end
endmodule
